// *** hw/smct_top.sv ***
// serial master channel with chained receive/transmit byte moves
// assumes an Avalon-MM master on REF_CLK and a clocked serial slave
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
module smct_top import smct_pkg::*; #(
  parameter int HALF_BIT = HALF_BIT_CYCLES
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // avalon-mm slave
  input  wire logic [19:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // serial link
  output logic             SHIFT_CLOCK_OUT,
  output logic             SERIAL_DATA_OUT,
  input  wire logic        SERIAL_DATA_IN,
  // interrupt request
  output logic             INT_REQUEST,
  output logic [1:0]       INT_LEVEL
);
  typedef struct packed {
    smct_dma_st_t     fsm;
    logic             ack;
    logic [31:0]      rdata;
    logic             enabled;
    logic             oe;
    logic             cko;
    logic             sol;
    logic             act_en;
    logic             mask;
    logic             flag;
    logic             pend;
    logic [PTR_W-1:0] dst;
    logic [PTR_W-1:0] src;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       rx;
    logic             sdi_meta;
    logic             sdi_sync;
  } smct_top_st_t;

  localparam smct_top_st_t RESET_ST = '{
    fsm: DMA_IDLE, cko: 1'b1, mask: MASK_RESET,
    dst: RX_DST_RESET, src: TX_SRC_RESET, default: '0};

  smct_top_st_t  s_ff, nxt_s;
  smct_avs_req_t req;

  logic        shf_start;
  logic [7:0]  shf_tx;
  logic        shf_busy;
  logic        shf_done;
  logic [7:0]  shf_rx;
  logic        ram_bus_we;
  logic [31:0] ram_bus_rdata;
  logic        dma_we;
  logic [7:0]  dma_rdata;
  logic [31:0] rd_mux;
  logic        wr;
  logic        in_ram;

  assign req = '{read: AVS_READ, write: AVS_WRITE,
                 address: AVS_ADDRESS, writedata: AVS_WRITEDATA,
                 byteenable: AVS_BYTEENABLE};
  assign in_ram = req.address[19:5] == RAM_BASE_ADDR[19:5];

  always_comb begin
    nxt_s      = s_ff;
    shf_start  = 1'b0;
    shf_tx     = 8'h00;
    dma_we     = 1'b0;
    ram_bus_we = 1'b0;
    wr         = s_ff.ack && req.write;
    nxt_s.sdi_meta = SERIAL_DATA_IN;
    nxt_s.sdi_sync = s_ff.sdi_meta;

    // read mux; unmapped addresses read zero
    rd_mux = 32'h0000_0000;
    if (req.address == CTRL_ADDR) begin
      rd_mux[CTRL_START_BIT] = s_ff.enabled;
      rd_mux[CTRL_OE_BIT]    = s_ff.oe;
      rd_mux[CTRL_CKO_BIT]   = s_ff.cko;
      rd_mux[CTRL_SOL_BIT]   = s_ff.sol;
      rd_mux[CTRL_ACT_BIT]   = s_ff.act_en;
      rd_mux[CTRL_MASK_BIT]  = s_ff.mask;
      rd_mux[CTRL_FLAG_BIT]  = s_ff.flag;
      rd_mux[CTRL_BUSY_BIT]  = shf_busy;
    end else if (req.address == DESC_ADDR) begin
      rd_mux[DESC_DST_LSB +: PTR_W] = s_ff.dst;
      rd_mux[DESC_SRC_LSB +: PTR_W] = s_ff.src;
      rd_mux[DESC_CNT_LSB +: CNT_W] = s_ff.cnt;
    end else if (req.address == SHIFT_DATA_ADDR) begin
      rd_mux[7:0] = s_ff.rx;
    end else if (in_ram) begin
      rd_mux = ram_bus_rdata;
    end

    // one wait state; held off while a move is due or running
    nxt_s.ack = (req.read || req.write) && !s_ff.ack &&
                s_ff.fsm == DMA_IDLE && !s_ff.pend;
    if (nxt_s.ack && req.read) begin
      nxt_s.rdata = rd_mux;
    end

    if (wr && req.address == CTRL_ADDR && req.byteenable[0]) begin
      if (req.writedata[CTRL_START_BIT]) begin
        nxt_s.enabled = 1'b1;
      end
      if (req.writedata[CTRL_STOP_BIT]) begin
        nxt_s.enabled = 1'b0;
      end
      nxt_s.oe     = req.writedata[CTRL_OE_BIT];
      nxt_s.cko    = req.writedata[CTRL_CKO_BIT];
      nxt_s.sol    = req.writedata[CTRL_SOL_BIT];
      nxt_s.act_en = req.writedata[CTRL_ACT_BIT];
      nxt_s.mask   = req.writedata[CTRL_MASK_BIT];
      // software may only clear the flag
      nxt_s.flag   = s_ff.flag && req.writedata[CTRL_FLAG_BIT];
    end
    if (wr && req.address == DESC_ADDR) begin
      if (req.byteenable[0]) begin
        nxt_s.dst = req.writedata[DESC_DST_LSB +: PTR_W];
      end
      if (req.byteenable[1]) begin
        nxt_s.src = req.writedata[DESC_SRC_LSB +: PTR_W];
      end
      if (req.byteenable[2]) begin
        nxt_s.cnt = req.writedata[DESC_CNT_LSB +: CNT_W];
      end
    end
    // a write while shifting or disabled is dropped
    if (wr && req.address == SHIFT_DATA_ADDR && req.byteenable[0] &&
        s_ff.enabled && s_ff.oe && !shf_busy) begin
      shf_start = 1'b1;
      shf_tx    = req.writedata[7:0];
    end
    ram_bus_we = wr && in_ram;

    if (shf_done) begin
      nxt_s.pend = 1'b1;
      nxt_s.rx   = shf_rx;
    end

    case (s_ff.fsm)
      DMA_IDLE: begin
        if (s_ff.pend && !s_ff.ack) begin
          nxt_s.pend = 1'b0;
          if (s_ff.act_en && s_ff.cnt != '0) begin
            nxt_s.fsm = DMA_RX;
          end else begin
            nxt_s.flag = 1'b1;
          end
        end
      end
      DMA_RX: begin
        dma_we    = 1'b1;
        nxt_s.dst = s_ff.dst + 5'h01;
        nxt_s.fsm = DMA_TX;
      end
      DMA_TX: begin
        shf_start = 1'b1;
        shf_tx    = dma_rdata;
        nxt_s.src = s_ff.src + 5'h01;
        nxt_s.cnt = s_ff.cnt - 4'h1;
        if (s_ff.cnt == 4'h1) begin
          nxt_s.act_en = 1'b0;
        end
        nxt_s.fsm = DMA_IDLE;
      end
      default: begin
        nxt_s.fsm = DMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_ff <= RESET_ST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  smct_shifter #(
    .HALF_BIT (HALF_BIT)
  ) u_shifter (
    .clk      (REF_CLK),
    .rst      (RST),
    .start    (shf_start),
    .tx_byte  (shf_tx),
    .idle_clk (s_ff.cko),
    .idle_dat (s_ff.sol),
    .sdi      (s_ff.sdi_sync),
    .sck      (SHIFT_CLOCK_OUT),
    .sdo      (SERIAL_DATA_OUT),
    .busy     (shf_busy),
    .done     (shf_done),
    .rx_byte  (shf_rx)
  );

  smct_ram #(
    .WORDS (RAM_WORDS)
  ) u_ram (
    .clk       (REF_CLK),
    .bus_we    (ram_bus_we),
    .bus_idx   (req.address[4:2]),
    .bus_be    (req.byteenable),
    .bus_wdata (req.writedata),
    .bus_rdata (ram_bus_rdata),
    .dma_we    (dma_we),
    .dma_widx  (s_ff.dst),
    .dma_wdata (s_ff.rx),
    .dma_ridx  (s_ff.src),
    .dma_rdata (dma_rdata)
  );

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_ff.ack;
  assign AVS_READDATA    = s_ff.rdata;
  assign INT_REQUEST     = s_ff.flag && !s_ff.mask;
  assign INT_LEVEL       = IRQ_LEVEL;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence dma_pair_s;
    s_ff.fsm == DMA_RX ##1 s_ff.fsm == DMA_TX ##1 s_ff.fsm == DMA_IDLE;
  endsequence

  sequence due_s;
    s_ff.fsm == DMA_IDLE && s_ff.pend && !s_ff.ack;
  endsequence

  move_order_a: assert property (
    $rose(s_ff.fsm == DMA_RX) |-> dma_pair_s)
    else $error("moves not receive then transmit");
  rx_dest_step_a: assert property (
    s_ff.fsm == DMA_RX |-> dma_we ##1 s_ff.dst == $past(s_ff.dst) + 5'h01)
    else $error("receive pointer did not step");
  tx_load_a: assert property (
    s_ff.fsm == DMA_TX |-> shf_start && shf_tx == dma_rdata
      ##1 shf_busy && s_ff.src == $past(s_ff.src) + 5'h01)
    else $error("transmit move did not load the shifter");
  no_shift_move_a: assert property (
    s_ff.fsm != DMA_IDLE |-> !shf_busy)
    else $error("shifting while a move is pending");
  event_to_move_a: assert property (
    due_s and (s_ff.act_en && s_ff.cnt != '0) |=>
      s_ff.fsm == DMA_RX && !$rose(s_ff.flag))
    else $error("end event with count left did not start moves");
  last_irq_a: assert property (
    due_s and !(s_ff.act_en && s_ff.cnt != '0) |=>
      s_ff.flag && INT_REQUEST == !s_ff.mask)
    else $error("exhausted count did not raise request");
  count_stop_a: assert property (
    s_ff.fsm == DMA_TX && s_ff.cnt == 4'h1 |=> !s_ff.act_en)
    else $error("activation not withdrawn at zero count");
  bus_answer_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && s_ff.fsm == DMA_IDLE
      && !s_ff.pend |=> !AVS_WAITREQUEST)
    else $error("idle slave did not answer in one cycle");

endmodule // smct_top

// *** common/smct_pkg.sv ***
// constants, types and register map of the chained serial master
// assumes a 100 MHz clock and a byte-addressed 20-bit register bus
package smct_pkg;

  // register map (byte addresses)
  localparam logic [19:0] SHIFT_DATA_ADDR = 20'hFFF10;
  localparam logic [19:0] CTRL_ADDR       = 20'hFFF00;
  localparam logic [19:0] DESC_ADDR       = 20'hFFF04;
  localparam logic [19:0] RAM_BASE_ADDR   = 20'hFE900;
  localparam int          RAM_WORDS       = 8;

  // control register, byte lane 0 plus busy
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OE_BIT    = 1;
  localparam int CTRL_CKO_BIT   = 2;
  localparam int CTRL_SOL_BIT   = 3;
  localparam int CTRL_ACT_BIT   = 4;
  localparam int CTRL_MASK_BIT  = 5;
  localparam int CTRL_FLAG_BIT  = 6;
  localparam int CTRL_STOP_BIT  = 7;
  localparam int CTRL_BUSY_BIT  = 8;

  // descriptor register fields
  localparam int DESC_DST_LSB = 0;
  localparam int DESC_SRC_LSB = 8;
  localparam int DESC_CNT_LSB = 16;
  localparam int PTR_W        = 5;
  localparam int CNT_W        = 4;

  // reset values
  localparam logic             MASK_RESET   = 1'b1;
  localparam logic [PTR_W-1:0] RX_DST_RESET = 5'h00;
  localparam logic [PTR_W-1:0] TX_SRC_RESET = 5'h11;

  // session and character format
  localparam int         MIN_BYTES = 2;
  localparam int         MAX_BYTES = 16;
  localparam int         CHAR_BITS = 8;
  localparam logic [1:0] IRQ_LEVEL = 2'h3;

  // timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int BAUD_BPS        = 9600;
  localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * BAUD_BPS);

  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_RX   = 2'b01,
    DMA_TX   = 2'b10
  } smct_dma_st_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [19:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } smct_avs_req_t;

endpackage

// *** hw/smct_shifter.sv ***
// three-wire shift engine: 8-bit, msb first, clock idles at idle_clk
// assumes sdi is already synchronised to clk
`timescale 1ns/10ps
module smct_shifter import smct_pkg::*; #(
  parameter int HALF_BIT = HALF_BIT_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       idle_clk,
  input  wire logic       idle_dat,
  // link
  input  wire logic       sdi,
  output logic            sck,
  output logic            sdo,
  // status
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte
);
  localparam int TW = $clog2(HALF_BIT);
  localparam logic [TW-1:0] TLOAD = TW'(HALF_BIT - 1);

  typedef struct packed {
    logic          busy;
    logic          phase;
    logic [2:0]    bitn;
    logic [TW-1:0] timer;
    logic [7:0]    shreg;
    logic          sck;
    logic          sdo;
    logic          done;
    logic [7:0]    rxb;
  } smct_shf_st_t;

  smct_shf_st_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (!s_ff.busy) begin
      nxt_s.sck = idle_clk;
      nxt_s.sdo = idle_dat;
      if (start) begin
        // type 1: data leaves on the falling edge, sampled on the rise
        nxt_s.busy  = 1'b1;
        nxt_s.phase = 1'b0;
        nxt_s.bitn  = 3'h0;
        nxt_s.timer = TLOAD;
        nxt_s.shreg = tx_byte;
        nxt_s.sck   = 1'b0;
        nxt_s.sdo   = tx_byte[CHAR_BITS-1];
      end
    end else if (s_ff.timer != '0) begin
      nxt_s.timer = s_ff.timer - 1'b1;
    end else begin
      nxt_s.timer = TLOAD;
      if (!s_ff.phase) begin
        nxt_s.sck   = 1'b1;
        nxt_s.phase = 1'b1;
        nxt_s.shreg = {s_ff.shreg[6:0], sdi};
      end else if (s_ff.bitn == 3'h7) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
        nxt_s.rxb  = s_ff.shreg;
        nxt_s.sck  = idle_clk;
        nxt_s.sdo  = idle_dat;
      end else begin
        nxt_s.bitn  = s_ff.bitn + 3'h1;
        nxt_s.phase = 1'b0;
        nxt_s.sck   = 1'b0;
        nxt_s.sdo   = s_ff.shreg[CHAR_BITS-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '{sck: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sck     = s_ff.sck;
  assign sdo     = s_ff.sdo;
  assign busy    = s_ff.busy;
  assign done    = s_ff.done;
  assign rx_byte = s_ff.rxb;

  // rising shift clock edges counted per character
  logic [3:0] rises_ff;
  always_ff @(posedge clk) begin
    if (rst || start) begin
      rises_ff <= 4'h0;
    end else if (!s_ff.sck && nxt_s.sck && s_ff.busy) begin
      rises_ff <= rises_ff + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  char_bits_a: assert property (
    $rose(done) |-> rises_ff == 4'h8)
    else $error("character did not carry eight clock rises");
  msb_first_a: assert property (
    (start && !busy) |=> (sdo == $past(tx_byte[7])) && !sck && busy)
    else $error("first bit out is not the msb");
  idle_clock_a: assert property (
    (!busy && !$past(busy) && $stable(idle_clk)) |-> sck == idle_clk)
    else $error("shift clock not at idle level");

endmodule // smct_shifter

// *** hw/smct_ram.sv ***
// 32-byte transfer buffer: word port for software, byte port for moves
// assumes the two write ports are never used in the same cycle
`timescale 1ns/10ps
module smct_ram import smct_pkg::*; #(
  parameter int WORDS = RAM_WORDS
) (
  // clock
  input  wire logic                       clk,
  // bus word port
  input  wire logic                       bus_we,
  input  wire logic [$clog2(WORDS)-1:0]   bus_idx,
  input  wire logic [3:0]                 bus_be,
  input  wire logic [31:0]                bus_wdata,
  output logic      [31:0]                bus_rdata,
  // byte port
  input  wire logic                       dma_we,
  input  wire logic [$clog2(WORDS*4)-1:0] dma_widx,
  input  wire logic [7:0]                 dma_wdata,
  input  wire logic [$clog2(WORDS*4)-1:0] dma_ridx,
  output logic      [7:0]                 dma_rdata
);
  typedef struct packed {
    logic [WORDS*4-1:0][7:0] mem;
  } smct_ram_st_t;

  smct_ram_st_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (dma_we) begin
      nxt_s.mem[dma_widx] = dma_wdata;
    end else if (bus_we) begin
      for (int b = 0; b < 4; b++) begin
        if (bus_be[b]) begin
          nxt_s.mem[{bus_idx, 2'(b)}] = bus_wdata[b*8 +: 8];
        end
      end
    end
  end

  // contents are data, not control: no reset
  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  assign dma_rdata = s_ff.mem[dma_ridx];
  always_comb begin
    bus_rdata = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      bus_rdata[b*8 +: 8] = s_ff.mem[{bus_idx, 2'(b)}];
    end
  end

endmodule // smct_ram

// *** verification/smct_slave_model.sv ***
// clocked three-wire slave: answers a byte for every eight shift clocks
// assumes the master idles the clock high and shifts msb first
`timescale 1ns/10ps
module smct_slave_model (
  // reset
  input  wire logic rst,
  // link
  input  wire logic shift_clock_out,
  input  wire logic serial_data_out,
  output logic      serial_data_in
);
  logic [7:0] got [0:63];
  logic [7:0] shreg;
  logic [7:0] txreg;
  int         nbytes;
  int         nbits;

  function automatic logic [7:0] reply(input int k);
    return 8'hC3 ^ 8'(k * 29);
  endfunction

  initial begin
    nbytes         = 0;
    nbits          = 0;
    shreg          = 8'h00;
    serial_data_in = 1'b0;
  end

  // falling edge puts the next bit out, msb first
  always @(negedge shift_clock_out) begin
    txreg = reply(nbytes);
    serial_data_in <= txreg[7 - nbits];
  end

  // rising edge takes the master's bit
  always @(posedge shift_clock_out) begin
    if (rst) begin
      nbits = 0;
    end else begin
      shreg = {shreg[6:0], serial_data_out};
      nbits++;
      if (nbits == 8) begin
        got[nbytes] = shreg;
        nbytes++;
        nbits = 0;
        // line is released: show the inverse, not the last bit
        serial_data_in <= ~serial_data_in;
      end
    end
  end
endmodule // smct_slave_model

// *** verification/serial_master_chained_transfer_test.sv ***
// register-level tests of the chained serial master against a slave model
// assumes smct_top with a shortened bit time and Avalon-MM with waitrequest
`timescale 1ns/10ps
module serial_master_chained_transfer_test;
  import smct_pkg::*;

  // four clock cycles per half bit: an 80 ns shift clock period
  localparam int HB = 4;

  logic        clk;
  logic        rst;
  logic [19:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sck;
  logic        sdo;
  logic        sdi;
  logic        int_request;
  logic [1:0]  int_level;
  int          err_count;
  int          compares;
  logic [31:0] rd;

  smct_top #(.HALF_BIT(HB)) dut (
    .REF_CLK         (clk),
    .RST             (rst),
    .AVS_ADDRESS     (avs_address),
    .AVS_READ        (avs_read),
    .AVS_WRITE       (avs_write),
    .AVS_WRITEDATA   (avs_writedata),
    .AVS_BYTEENABLE  (avs_byteenable),
    .AVS_READDATA    (avs_readdata),
    .AVS_WAITREQUEST (avs_waitrequest),
    .SHIFT_CLOCK_OUT (sck),
    .SERIAL_DATA_OUT (sdo),
    .SERIAL_DATA_IN  (sdi),
    .INT_REQUEST     (int_request),
    .INT_LEVEL       (int_level)
  );

  smct_slave_model slave (
    .rst             (rst),
    .shift_clock_out (sck),
    .serial_data_out (sdo),
    .serial_data_in  (sdi)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [19:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    // waitrequest and read data are both taken at the rising edge
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) err_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  function automatic logic [7:0] txb(input int s, input int i);
    return 8'(i * 37 + s * 11 + 85);
  endfunction

  function automatic logic [7:0] reply(input int k);
    return 8'hC3 ^ 8'(k * 29);
  endfunction

  task automatic run(input int s, input int nb);
    int          base;
    int          n;
    logic [31:0] w;
    logic [7:0]  e;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 4; b++) w[8*b +: 8] = txb(s, 4*k + b);
      bus(1'b1, RAM_BASE_ADDR + 20'(16 + 4*k), w, rd);
      bus(1'b1, RAM_BASE_ADDR + 20'(4*k), 32'h0, rd);
    end
    bus(1'b1, DESC_ADDR, {12'h0, 4'(nb - 1), 8'h11, 8'h00}, rd);
    bus(1'b1, CTRL_ADDR, 32'h17, rd);
    base = slave.nbytes;
    bus(1'b1, SHIFT_DATA_ADDR, {24'h0, txb(s, 0)}, rd);
    n = 0;
    while (int_request !== 1'b1 && n < 4000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 4000) err_count++;
    chk("bytes before irq", 32'(slave.nbytes - base), 32'(nb));
    for (int i = 0; i < nb; i++)
      chk("slave got", {24'h0, slave.got[base+i]}, {24'h0, txb(s, i)});
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, RAM_BASE_ADDR + 20'(4*k), 32'h0, rd);
      for (int b = 0; b < 4; b++) begin
        e = (4*k + b < nb - 1) ? reply(base + 4*k + b) : 8'h00;
        chk("rx buffer", {24'h0, rd[8*b +: 8]}, {24'h0, e});
      end
    end
    bus(1'b0, SHIFT_DATA_ADDR, 32'h0, rd);
    chk("last byte", {24'h0, rd[7:0]}, {24'h0, reply(base+nb-1)});
    bus(1'b0, DESC_ADDR, 32'h0, rd);
    chk("desc", {rd[19:16], rd[12:8], rd[4:0]},
        {18'h0, 4'h0, 5'(17 + nb - 1), 5'(nb - 1)});
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    chk("ctrl done", {23'h0, rd[8:0]}, 32'h47);
    chk("clock idle", {31'h0, sck}, 32'h1);
    bus(1'b1, CTRL_ADDR, 32'h07, rd);
    // the clear lands at the edge the write is answered: look one later
    @(posedge clk);
    chk("irq cleared", {31'h0, int_request}, 32'h0);
  endtask

  initial begin
    err_count      = 0;
    compares       = 0;
    rst            = 1'b1;
    avs_address    = 20'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk("irq level", {30'h0, int_level}, 32'h3);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    chk("ctrl reset", {23'h0, rd[8:0]}, 32'h24);
    bus(1'b0, DESC_ADDR, 32'h0, rd);
    chk("desc reset", {12'h0, rd[19:0]}, 32'h1100);
    bus(1'b0, 20'hFFF20, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // output still disabled: the byte must not start
    bus(1'b1, SHIFT_DATA_ADDR, 32'hAA, rd);
    repeat (40) @(posedge clk);
    chk("no shift", 32'(slave.nbytes), 32'h0);
    chk("data idle", {31'h0, sdo}, 32'h0);
    run(0, 2);
    run(1, 16);
    run(2, 4);
    // opposite idle levels: clock low, data high
    bus(1'b1, CTRL_ADDR, 32'h0A, rd);
    repeat (2) @(posedge clk);
    chk("idle levels", {30'h0, sck, sdo}, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule // serial_master_chained_transfer_test
